//--- src/adcc_pkg.sv
package adcc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register offsets (word index on the plain port)
	localparam logic [ADDR_W-1:0] OFF_TIMING = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_INSEL = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
	// Timing control fields
	localparam int CLKSRC_BIT = 15;
	localparam int EXTENDED_SAMPLING_FLAG_BIT = 14;
	localparam int RSVD_BIT = 13;
	localparam int AUTO_SAMPLE_PERIODS_LSB = 8;
	localparam int AUTO_SAMPLE_PERIODS_W = 5;
	localparam int CONV_CLOCK_DIVIDER_LSB = 0;
	localparam int CONV_CLOCK_DIVIDER_W = 8;
	localparam logic [CONV_CLOCK_DIVIDER_W-1:0] CONV_CLOCK_DIVIDER_MAX = 8'h3f;
	// Input select fields
	localparam int NB_LSB = 13;
	localparam int SB_LSB = 8;
	localparam int NA_LSB = 5;
	localparam int SA_LSB = 0;
	localparam int NSEL_W = 3;
	localparam int PSEL_W = 5;
	localparam logic [PSEL_W-1:0] PS_CH_MAX = 5'h15;
	localparam logic [PSEL_W-1:0] PS_FLOAT_LO = 5'h16;
	localparam logic [PSEL_W-1:0] PS_FLOAT_HI = 5'h18;
	localparam logic [PSEL_W-1:0] PS_BANDGAP = 5'h1a;
	localparam logic [PSEL_W-1:0] PS_GUARD_LO = 5'h1b;
	localparam logic [PSEL_W-1:0] PS_GUARD_HI = 5'h1c;
	localparam logic [PSEL_W-1:0] PS_GROUND = 5'h1d;
	localparam logic [PSEL_W-1:0] PS_SUPPLY = 5'h1e;
	// Control register bits
	localparam int CTL_MANUAL_SAMPLE_REQUEST_BIT = 0;
	localparam int CTL_START_BIT = 1;
	localparam int CTL_MUXA_BIT = 2;
	localparam int CTL_POSITIVE_REF_CONFIG_LSB = 4;
	localparam int CTL_BG4X_BIT = 6;
	localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;
	// Source kinds presented to the analog front end
	typedef enum logic [2:0] {
		SRC_CHANNEL = 3'h0,
		SRC_FLOAT = 3'h1,
		SRC_BANDGAP = 3'h2,
		SRC_GUARD_LO = 3'h3,
		SRC_GUARD_HI = 3'h4,
		SRC_GROUND = 3'h5,
		SRC_SUPPLY = 3'h6,
		SRC_ILLEGAL = 3'h7
	} adcc_src_type;
endpackage

//--- src/adcc_div.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_div #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clr,
	input wire logic [W-1:0] sel,
	output logic tick
);
	logic [W-1:0] cnt_q, cnt_d;
	logic tick_d;
	if (W < 2) begin : g_w_chk
		$error("adcc_div width too small");
	end
	// Period of (sel+1) cycles; one-cycle tick at the end
	always_comb begin
		tick_d = 1'b0;
		cnt_d = cnt_q + 1'b1;
		if (clr) begin
			cnt_d = '0;
		end else if (cnt_q >= sel) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule
`default_nettype wire

//--- src/adcc_top.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module adcc_top
	import adcc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [adcc_pkg::ADDR_W-1:0] addr,
	input wire logic [adcc_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [adcc_pkg::DATA_W-1:0] rdata,
	output logic sampling,
	output logic conv_tick,
	output logic pos_is_channel,
	output logic [adcc_pkg::PSEL_W-1:0] pos_channel,
	output adcc_pkg::adcc_src_type pos_source,
	output logic bandgap_4x,
	output logic neg_is_ground,
	output logic [adcc_pkg::NSEL_W-1:0] neg_channel,
	output logic temp_sensor_sel
);
	import adcc_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MANUAL = 3'b010,
		ST_AUTO = 3'b100
	} adcc_state_type;

	logic [DATA_W-1:0] timing_q, timing_d, insel_q, insel_d, ctl_q, ctl_d, rdata_d;
	adcc_state_type st_q, st_d;
	logic [AUTO_SAMPLE_PERIODS_W-1:0] scnt_q, scnt_d;
	logic extended_sampling_flag_q, extended_sampling_flag_d, tick;
	logic [AUTO_SAMPLE_PERIODS_W-1:0] auto_sample_periods;
	logic [CONV_CLOCK_DIVIDER_W-1:0] conv_clock_divider;
	logic manual, use_a, div_clr;
	logic [PSEL_W-1:0] psel;
	logic [NSEL_W-1:0] nsel;
	adcc_src_type src_d;
	logic pch_d, ngnd_d, temp_d, bg4_d;
	logic [PSEL_W-1:0] pchan_d;
	logic [NSEL_W-1:0] nchan_d;

	assign auto_sample_periods = timing_q[AUTO_SAMPLE_PERIODS_LSB +: AUTO_SAMPLE_PERIODS_W];
	assign conv_clock_divider = timing_q[CONV_CLOCK_DIVIDER_LSB +: CONV_CLOCK_DIVIDER_W];
	assign manual = ctl_q[CTL_MANUAL_SAMPLE_REQUEST_BIT];
	assign use_a = ctl_q[CTL_MUXA_BIT];
	// Restart the period when the auto phase begins, so every period counted is whole
	assign div_clr = (st_q == ST_IDLE) || (st_q == ST_MANUAL && !manual);

	// Conversion clock period
	adcc_div #(.W(CONV_CLOCK_DIVIDER_W)) u_div (
		.clk(clk),
		.arst_n(arst_n),
		.clr(div_clr),
		.sel(conv_clock_divider),
		.tick(tick)
	);

	// Register file
	always_comb begin
		timing_d = timing_q;
		insel_d = insel_q;
		ctl_d = ctl_q;
		rdata_d = RST_ZERO;
		ctl_d[CTL_START_BIT] = 1'b0;
		if (wr) begin
			unique case (addr)
				OFF_TIMING: begin
					timing_d = wdata;
					timing_d[EXTENDED_SAMPLING_FLAG_BIT] = 1'b0;
					timing_d[RSVD_BIT] = 1'b0;
					if (wdata[CONV_CLOCK_DIVIDER_LSB +: CONV_CLOCK_DIVIDER_W] > CONV_CLOCK_DIVIDER_MAX) begin
						timing_d[CONV_CLOCK_DIVIDER_LSB +: CONV_CLOCK_DIVIDER_W] = CONV_CLOCK_DIVIDER_MAX;
					end
				end
				OFF_INSEL: insel_d = wdata;
				OFF_STATUS: begin
					ctl_d = wdata;
					ctl_d[DATA_W-1:CTL_BG4X_BIT+1] = '0;
					ctl_d[CTL_START_BIT+2] = 1'b0;
				end
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				OFF_TIMING: begin
					rdata_d = timing_q;
					rdata_d[EXTENDED_SAMPLING_FLAG_BIT] = extended_sampling_flag_q;
				end
				OFF_INSEL: rdata_d = insel_q;
				OFF_STATUS: rdata_d = ctl_q;
				default: rdata_d = RST_ZERO;
			endcase
		end
	end

	// Sampling sequencer
	always_comb begin
		st_d = st_q;
		scnt_d = scnt_q;
		unique case (st_q)
			ST_IDLE: begin
				if (manual) begin
					st_d = ST_MANUAL;
				end else if (ctl_q[CTL_START_BIT]) begin
					st_d = ST_AUTO;
					scnt_d = auto_sample_periods;
				end
			end
			ST_MANUAL: begin
				if (!manual) begin
					st_d = ST_AUTO;
					scnt_d = auto_sample_periods;
				end
			end
			ST_AUTO: begin
				if (manual) begin
					st_d = ST_MANUAL;
				end else if (scnt_q == '0) begin
					st_d = ST_IDLE;
				end else if (tick) begin
					scnt_d = scnt_q - 1'b1;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		extended_sampling_flag_d = (st_d == ST_AUTO) && !manual;
	end

	// Input multiplexer decode
	always_comb begin
		psel = use_a ? insel_q[SA_LSB +: PSEL_W] : insel_q[SB_LSB +: PSEL_W];
		nsel = use_a ? insel_q[NA_LSB +: NSEL_W] : insel_q[NB_LSB +: NSEL_W];
		pch_d = 1'b0;
		pchan_d = '0;
		temp_d = 1'b0;
		src_d = SRC_FLOAT;
		if (psel <= PS_CH_MAX) begin
			src_d = SRC_CHANNEL;
			pch_d = 1'b1;
			pchan_d = psel;
		end else if (psel >= PS_FLOAT_LO && psel <= PS_FLOAT_HI) begin
			src_d = SRC_FLOAT;
			temp_d = (psel == PS_FLOAT_LO);
		end else begin
			unique case (psel)
				PS_BANDGAP: src_d = SRC_BANDGAP;
				PS_GUARD_LO: src_d = SRC_GUARD_LO;
				PS_GUARD_HI: src_d = SRC_GUARD_HI;
				PS_GROUND: src_d = SRC_GROUND;
				PS_SUPPLY: src_d = SRC_SUPPLY;
				default: src_d = SRC_ILLEGAL;
			endcase
		end
		// Multiple is picked by software only when the reference config is 1x
		bg4_d = (src_d == SRC_BANDGAP) && ctl_q[CTL_POSITIVE_REF_CONFIG_LSB+1] && ctl_q[CTL_BG4X_BIT];
		ngnd_d = (nsel == '0);
		nchan_d = ngnd_d ? '0 : nsel - 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timing_q <= RST_ZERO;
			insel_q <= RST_ZERO;
			ctl_q <= RST_ZERO;
			rdata <= RST_ZERO;
			st_q <= ST_IDLE;
			scnt_q <= '0;
			extended_sampling_flag_q <= 1'b0;
			sampling <= 1'b0;
			conv_tick <= 1'b0;
			pos_is_channel <= 1'b0;
			pos_channel <= '0;
			pos_source <= SRC_CHANNEL;
			bandgap_4x <= 1'b0;
			neg_is_ground <= 1'b1;
			neg_channel <= '0;
			temp_sensor_sel <= 1'b0;
		end else begin
			timing_q <= timing_d;
			insel_q <= insel_d;
			ctl_q <= ctl_d;
			rdata <= rdata_d;
			st_q <= st_d;
			scnt_q <= scnt_d;
			extended_sampling_flag_q <= extended_sampling_flag_d;
			sampling <= (st_d != ST_IDLE);
			conv_tick <= tick;
			pos_is_channel <= pch_d;
			pos_channel <= pchan_d;
			pos_source <= src_d;
			bandgap_4x <= bg4_d;
			neg_is_ground <= ngnd_d;
			neg_channel <= nchan_d;
			temp_sensor_sel <= temp_d;
		end
	end

	rsvd_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
		timing_q[RSVD_BIT] == 1'b0) else $error("reserved bit set");
	extended_sampling_flag_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd && addr == OFF_TIMING |=> rdata[EXTENDED_SAMPLING_FLAG_BIT] == $past(extended_sampling_flag_q))
		else $error("extended flag read wrong");
	extended_sampling_flag_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
		st_q == ST_IDLE |-> !extended_sampling_flag_q) else $error("flag set while idle");
	auto_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
		st_q == ST_AUTO && scnt_q == '0 && !manual |=> st_q == ST_IDLE)
		else $error("zero-length auto sample overran");
	div_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
		conv_clock_divider <= CONV_CLOCK_DIVIDER_MAX) else $error("divider above limit");
	chan_map_a: assert property (@(posedge clk) disable iff (!arst_n)
		!use_a && insel_q[SB_LSB +: PSEL_W] <= PS_CH_MAX && $stable(insel_q) && $stable(use_a)
		|=> pos_is_channel && pos_channel == $past(insel_q[SB_LSB +: PSEL_W]))
		else $error("channel map wrong");
	supply_map_a: assert property (@(posedge clk) disable iff (!arst_n)
		psel == PS_SUPPLY |=> pos_source == SRC_SUPPLY) else $error("supply map wrong");
	float_map_a: assert property (@(posedge clk) disable iff (!arst_n)
		psel == PS_FLOAT_LO |=> pos_source == SRC_FLOAT && temp_sensor_sel)
		else $error("float map wrong");
	bg_mult_a: assert property (@(posedge clk) disable iff (!arst_n)
		bandgap_4x |-> $past(psel) == PS_BANDGAP && $past(ctl_q[CTL_POSITIVE_REF_CONFIG_LSB+1])
		&& $past(ctl_q[CTL_BG4X_BIT]))
		else $error("band gap multiple wrong");
	neg_map_a: assert property (@(posedge clk) disable iff (!arst_n)
		nsel != '0 |=> !neg_is_ground && neg_channel == $past(nsel) - 3'h1)
		else $error("negative map wrong");
endmodule
`default_nettype wire

//--- tb/adcc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_top_bench;
	import adcc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic sampling, conv_tick, pos_is_channel, bandgap_4x, neg_is_ground, temp_sensor_sel;
	logic [PSEL_W-1:0] pos_channel;
	adcc_src_type pos_source;
	logic [NSEL_W-1:0] neg_channel;
	logic [DATA_W-1:0] exp_q[$];
	logic taken_q = 1'b0;
	logic [31:0] rs = 32'h0000_0053;
	int cyc = 0;
	int error_cnt = 0;
	int checked = 0;

	adcc_top u_adcc_top (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sampling(sampling), .conv_tick(conv_tick),
		.pos_is_channel(pos_is_channel), .pos_channel(pos_channel), .pos_source(pos_source),
		.bandgap_4x(bandgap_4x), .neg_is_ground(neg_is_ground), .neg_channel(neg_channel),
		.temp_sensor_sel(temp_sensor_sel));

	initial begin
		forever #10 clk = ~clk;
	end

	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	function automatic logic [15:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[15:0];
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic bus_read(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (taken_q) begin
			chk("rdata", rdata, exp_q.pop_front());
		end
		taken_q <= rd;
	end

	task automatic wait_tick(output int g);
		g = 0;
		do begin
			settle(1);
			g++;
		end while (conv_tick !== 1'b1 && g < 600);
		if (g >= 600) begin
			error_cnt++;
			complete_run();
		end
	endtask

	// Manual phase or start pulse, then auto phase of sc conversion clock periods
	task automatic seq_run(input logic [4:0] sc, input logic [7:0] dv, input logic go);
		int g;
		int t0;
		int n;
		bus_write(OFF_TIMING, {3'b000, sc, dv});
		if (!go) begin
			bus_write(4'h2, 16'h0001);
			wait_tick(g);
			wait_tick(g);
			chk("tick gap", 16'(g), 16'(dv) + 16'h0001);
			bus_read(OFF_TIMING, {3'b000, sc, dv});
		end
		bus_write(4'h2, go ? 16'h0002 : 16'h0000);
		#1;
		t0 = cyc;
		if (sc != 5'h00) bus_read(OFF_TIMING, {3'b010, sc, dv});
		for (n = 0; n < 3000 && sampling !== 1'b0; n++) settle(1);
		if (n == 3000) begin
			error_cnt++;
			complete_run();
		end
		n = cyc - t0 - int'(sc) * (int'(dv) + 1);
		chk("auto length", 16'(n >= 0 && n <= 3), 16'h0001);
		bus_read(OFF_TIMING, {3'b000, sc, dv});
	endtask

	initial begin
		logic [15:0] r;
		logic [15:0] v;
		logic [2:0] ng;
		adcc_src_type es;
		repeat (10) @(posedge clk);
		#1;
		chk("neg gnd rst", 16'(neg_is_ground), 16'h0001);
		arst_n <= 1'b1;
		bus_read(OFF_TIMING, 16'h0000);
		bus_read(OFF_INSEL, 16'h0000);
		bus_write(OFF_TIMING, 16'hdfff);
		bus_read(OFF_TIMING, 16'h9f3f);
		bus_write(4'h7, 16'hffff);
		bus_read(4'h7, 16'h0000);
		for (int m = 0; m < 2; m++) begin
			bus_write(4'h2, m[0] ? 16'h0004 : 16'h0000);
			for (int c = 0; c < 32; c++) begin
				r = rnd();
				ng = r[2:0];
				v = m[0] ? {r[15:8], ng, c[4:0]} : {ng, c[4:0], r[7:0]};
				case (c)
					26: es = SRC_BANDGAP;
					27: es = SRC_GUARD_LO;
					28: es = SRC_GUARD_HI;
					29: es = SRC_GROUND;
					30: es = SRC_SUPPLY;
					25, 31: es = SRC_ILLEGAL;
					default: es = (c <= 21) ? SRC_CHANNEL : SRC_FLOAT;
				endcase
				bus_write(OFF_INSEL, v);
				settle(2);
				chk("source", 16'(pos_source), 16'(es));
				chk("is chan", 16'(pos_is_channel), 16'(es == SRC_CHANNEL));
				if (es == SRC_CHANNEL) chk("chan", 16'(pos_channel), 16'(c));
				chk("temp", 16'(temp_sensor_sel), 16'(c == 22));
				chk("neg gnd", 16'(neg_is_ground), 16'(ng == 3'h0));
				if (ng != 3'h0) chk("neg chan", 16'(neg_channel), 16'(ng - 3'h1));
				bus_read(OFF_INSEL, v);
			end
		end
		bus_write(OFF_INSEL, 16'h1a00);
		for (int k = 0; k < 4; k++) begin
			bus_write(4'h2, {9'h000, k[0], k[1], 5'h10});
			settle(2);
			chk("bg 4x", 16'(bandgap_4x), 16'(k == 3));
		end
		seq_run(5'h00, 8'h01, 1'b0);
		seq_run(5'h05, 8'h03, 1'b0);
		seq_run(5'h1f, 8'h3f, 1'b0);
		seq_run(5'h02, 8'h01, 1'b1);
		settle(4);
		complete_run();
	end

	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
